// file: rtl/ebac_ctrl.sv
// Byte read/program controller for the 4K-byte data EEPROM.
//
// How it works
// - 4K-byte array, single bytes read and written
// - 12-bit pointer split over high/low registers
// - Reserved pointer/control bits read zero
// - Program writes buffer byte to pointer
// - Read puts addressed byte in buffer
// - Read strobe stalls processor four cycles
// - Program strobe stalls processor two cycles
// - Mode field picks atomic or split action
// - 00 atomic, 01 erase, 10 write, 11 reserved
// - Mode writes ignored while programming
// - Reset clears mode unless programming runs
// - Self-timed programming reports completion
// - Registers sit in the I/O space
// - Arm opens four-cycle strobe window
// - Strobe stays set until programming ends
// - Immediate read; blocked while programming
// - Ready interrupt while enabled and idle
`timescale 1ns/1ps
`default_nettype none

module ebac_ctrl #(
	parameter int TICK_DIV_P     = ebac_pkg::TICK_DIV,
	parameter int ATOMIC_TICKS_P = ebac_pkg::ATOMIC_TICKS,
	parameter int SPLIT_TICKS_P  = ebac_pkg::SPLIT_TICKS
) (
	input  wire logic       ref_clk,       // CPU clock
	input  wire logic       rst_b,         // Sync reset, low
	input  wire logic [5:0] io_addr,       // I/O register offset
	input  wire logic       io_wr_en,      // I/O write strobe
	input  wire logic       io_rd_en,      // I/O read strobe
	input  wire logic [7:0] io_wdata,      // I/O write data
	input  wire logic       global_irq_en, // Global enable
	output logic      [7:0] io_rdata,      // Registered read data
	output logic            cpu_stall,     // Halt the core
	output logic            ready_irq      // Ready interrupt level
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam int AW = ebac_pkg::ADDR_W;

	logic [7:0]    mem_reg [ebac_pkg::ARRAY_BYTES];
	logic [AW-1:0] ptr_reg,     ptr_next;
	logic [7:0]    buf_reg,     buf_next;
	logic          rie_reg,     rie_next;
	logic [2:0]    arm_cnt_reg, arm_cnt_next;
	logic          arm_reg,     arm_next;
	logic [2:0]    stall_cnt_reg, stall_cnt_next;
	logic [7:0]    rdata_reg,   rdata_next;
	logic          stall_reg,   stall_next;
	logic          irq_reg,     irq_next;

	// Programming engine: survives reset while busy
	ebac_pkg::ebac_action_t mode_reg, mode_next;
	logic          busy_reg,    busy_next;
	logic [11:0]   timer_reg,   timer_next;
	logic [3:0]    div_reg,     div_next;
	logic [AW-1:0] op_addr_reg, op_addr_next;
	logic [7:0]    op_data_reg, op_data_next;

	// Decoded accesses
	logic          wr_ctl;
	logic          wr_buf;
	logic          wr_lo;
	logic          wr_hi;
	logic          strobe_ok;
	logic          start_op;
	logic          tick;
	logic          done;
	logic [7:0]    commit_byte;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	// Registers are plain I/O locations of the core
	always_comb begin
		wr_ctl = io_wr_en && (io_addr == ebac_pkg::NVM_CONTROL_OFF);
		wr_buf = io_wr_en && (io_addr == ebac_pkg::NVM_BUFFER_OFF);
		wr_lo  = io_wr_en && (io_addr == ebac_pkg::NVM_PTR_LOW_OFF);
		wr_hi  = io_wr_en && (io_addr == ebac_pkg::NVM_PTR_HIGH_OFF);
		// Strobe only counts inside the arm window, never in reset
		strobe_ok = rst_b && wr_ctl && arm_reg && !busy_reg
			&& io_wdata[ebac_pkg::CTL_STROBE_BIT];
		// A reserved mode accepts the strobe but starts nothing
		start_op = strobe_ok
			&& (mode_reg != ebac_pkg::EBAC_RESERVED);
	end

	// ------------------------------------------------------------
	// Programming timebase
	// ------------------------------------------------------------
	// Divider runs only while busy, so an idle block draws nothing
	// and every operation starts on a whole tick boundary
	always_comb begin
		tick     = 1'b0;
		div_next = div_reg;
		if (busy_reg) begin
			if (div_reg == 4'(TICK_DIV_P - 1)) begin
				div_next = 4'h0;
				tick     = 1'b1;
			end else begin
				div_next = div_reg + 4'h1;
			end
		end else begin
			div_next = 4'h0;
		end
	end

	// ------------------------------------------------------------
	// Programming engine next state
	// ------------------------------------------------------------
	always_comb begin
		mode_next    = mode_reg;
		busy_next    = busy_reg;
		timer_next   = timer_reg;
		op_addr_next = op_addr_reg;
		op_data_next = op_data_reg;
		done         = busy_reg && tick && (timer_reg == 12'h001);
		// Mode field is frozen during programming
		if (wr_ctl && !busy_reg && rst_b) begin
			mode_next = ebac_pkg::ebac_action_t'(
				io_wdata[ebac_pkg::CTL_MODE_HI:ebac_pkg::CTL_MODE_LO]);
		end
		// Reset clears the mode only when nothing is running
		if (!rst_b && !busy_reg) begin
			mode_next = ebac_pkg::EBAC_ATOMIC;
		end
		if (start_op) begin
			busy_next    = 1'b1;
			op_addr_next = ptr_reg;
			op_data_next = buf_reg;
			// Duration chosen by the action
			unique case (mode_reg)
				ebac_pkg::EBAC_ATOMIC:
					timer_next = 12'(ATOMIC_TICKS_P);
				ebac_pkg::EBAC_ERASE_ONLY,
				ebac_pkg::EBAC_WRITE_ONLY:
					timer_next = 12'(SPLIT_TICKS_P);
				ebac_pkg::EBAC_RESERVED:
					timer_next = timer_reg;
			endcase
		end else if (busy_reg && tick) begin
			timer_next = timer_reg - 12'h001;
			if (done) begin
				busy_next = 1'b0;
			end
		end
	end

	// Byte stored when programming ends; write-only can only clear bits
	always_comb begin
		unique case (mode_reg)
			ebac_pkg::EBAC_ATOMIC:
				commit_byte = op_data_reg;
			ebac_pkg::EBAC_ERASE_ONLY:
				commit_byte = ebac_pkg::ERASED_BYTE;
			ebac_pkg::EBAC_WRITE_ONLY:
				commit_byte = mem_reg[op_addr_reg] & op_data_reg;
			ebac_pkg::EBAC_RESERVED:
				commit_byte = mem_reg[op_addr_reg];
		endcase
	end

	// Engine keeps running through reset; an unknown busy resets
	always_ff @(posedge ref_clk) begin
		if (rst_b || busy_reg) begin
			mode_reg    <= mode_next;
			busy_reg    <= busy_next;
			timer_reg   <= timer_next;
			div_reg     <= div_next;
			op_addr_reg <= op_addr_next;
			op_data_reg <= op_data_next;
		end else begin
			mode_reg    <= ebac_pkg::EBAC_ATOMIC;
			busy_reg    <= 1'b0;
			timer_reg   <= 12'h000;
			div_reg     <= 4'h0;
			op_addr_reg <= '0;
			op_data_reg <= ebac_pkg::RESET_BYTE;
		end
	end

	// Array write at the end of the timed operation
	always_ff @(posedge ref_clk) begin
		if (done) begin
			mem_reg[op_addr_reg] <= commit_byte;
		end
	end

	// ------------------------------------------------------------
	// CPU-facing registers next state
	// ------------------------------------------------------------
	always_comb begin
		ptr_next       = ptr_reg;
		buf_next       = buf_reg;
		rie_next       = rie_reg;
		arm_cnt_next   = arm_cnt_reg;
		stall_cnt_next = stall_cnt_reg;
		// Pointer locked while an operation uses it
		if (wr_lo && !busy_reg) begin
			ptr_next[7:0] = io_wdata;
		end
		if (wr_hi && !busy_reg) begin
			ptr_next[AW-1:8] = io_wdata[AW-9:0];
		end
		if (wr_buf) begin
			buf_next = io_wdata;
		end
		// Arm window counts down and then drops by itself
		if (arm_cnt_reg != 3'h0) begin
			arm_cnt_next = arm_cnt_reg - 3'h1;
		end
		if (stall_cnt_reg != 3'h0) begin
			stall_cnt_next = stall_cnt_reg - 3'h1;
		end
		if (wr_ctl) begin
			rie_next = io_wdata[ebac_pkg::CTL_RIE_BIT];
			if (io_wdata[ebac_pkg::CTL_ARM_BIT]) begin
				arm_cnt_next = ebac_pkg::ARM_WINDOW;
			end
			// Read is immediate, refused while programming
			if (io_wdata[ebac_pkg::CTL_FETCH_BIT] && !busy_reg) begin
				buf_next       = mem_reg[ptr_reg];
				stall_cnt_next = ebac_pkg::FETCH_STALL;
			end
		end
		// Accepted strobe consumes the arm window
		if (strobe_ok) begin
			arm_cnt_next   = 3'h0;
			stall_cnt_next = ebac_pkg::STROBE_STALL;
		end
		// Status levels follow the counters on the same edge
		arm_next   = (arm_cnt_next != 3'h0);
		stall_next = (stall_cnt_next != 3'h0);
		// Level interrupt, not a flag: it stands while idle and drops
		// at the strobe edge, so the core never sees a stale ready
		irq_next   = rie_next && global_irq_en && !busy_next;
	end

	// Read mux; reserved bits return zero
	// Data is held between reads so a late load by the core still sees it
	always_comb begin
		rdata_next = 8'h00;
		unique case (io_addr)
			ebac_pkg::NVM_CONTROL_OFF:
				rdata_next = {2'b00, mode_reg, rie_reg, arm_reg,
					busy_reg, 1'b0};
			ebac_pkg::NVM_BUFFER_OFF:
				rdata_next = buf_reg;
			ebac_pkg::NVM_PTR_LOW_OFF:
				rdata_next = ptr_reg[7:0];
			ebac_pkg::NVM_PTR_HIGH_OFF:
				rdata_next = {4'h0, ptr_reg[AW-1:8]};
			default:
				rdata_next = 8'h00;
		endcase
		if (!io_rd_en) begin
			rdata_next = rdata_reg;
		end
	end

	// Pointer is given a known value though software must load it
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ptr_reg       <= '0;
			buf_reg       <= ebac_pkg::RESET_BYTE;
			rie_reg       <= 1'b0;
			arm_cnt_reg   <= 3'h0;
			arm_reg       <= 1'b0;
			stall_cnt_reg <= 3'h0;
			stall_reg     <= 1'b0;
			rdata_reg     <= 8'h00;
			irq_reg       <= 1'b0;
		end else begin
			ptr_reg       <= ptr_next;
			buf_reg       <= buf_next;
			rie_reg       <= rie_next;
			arm_cnt_reg   <= arm_cnt_next;
			arm_reg       <= arm_next;
			stall_cnt_reg <= stall_cnt_next;
			stall_reg     <= stall_next;
			rdata_reg     <= rdata_next;
			irq_reg       <= irq_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign io_rdata  = rdata_reg;
	assign cpu_stall = stall_reg;
	assign ready_irq = irq_reg;

endmodule

`default_nettype wire

// file: pkg/ebac_pkg.sv
// Constants shared by the byte-access controller for the data EEPROM.
package ebac_pkg;

	// ------------------------------------------------------------
	// I/O register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] NVM_CONTROL_OFF  = 6'h1F;
	localparam logic [5:0] NVM_BUFFER_OFF   = 6'h20;
	localparam logic [5:0] NVM_PTR_LOW_OFF  = 6'h21;
	localparam logic [5:0] NVM_PTR_HIGH_OFF = 6'h22;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTL_FETCH_BIT  = 0;
	localparam int CTL_STROBE_BIT = 1;
	localparam int CTL_ARM_BIT    = 2;
	localparam int CTL_RIE_BIT    = 3;
	localparam int CTL_MODE_LO    = 4;
	localparam int CTL_MODE_HI    = 5;

	// ------------------------------------------------------------
	// Array geometry and reset values
	// ------------------------------------------------------------
	localparam int         ADDR_W      = 12;
	localparam int         ARRAY_BYTES = 4096;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] RESET_BYTE  = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIMEBASE_NS   = 1000;
	localparam int TICK_DIV      = TIMEBASE_NS / CLK_PERIOD_NS;
	localparam int ATOMIC_US     = 3400;
	localparam int SPLIT_US      = 1800;
	localparam int ATOMIC_TICKS  = ATOMIC_US * 1000 / TIMEBASE_NS;
	localparam int SPLIT_TICKS   = SPLIT_US * 1000 / TIMEBASE_NS;
	localparam logic [2:0] FETCH_STALL  = 3'h4;
	localparam logic [2:0] STROBE_STALL = 3'h2;
	localparam logic [2:0] ARM_WINDOW   = 3'h4;

	// ------------------------------------------------------------
	// Programming actions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EBAC_ATOMIC     = 2'b00,
		EBAC_ERASE_ONLY = 2'b01,
		EBAC_WRITE_ONLY = 2'b10,
		EBAC_RESERVED   = 2'b11
	} ebac_action_t;

endpackage

// file: verification/ebac_ctrl_asserts.sv
// Port checker for the data EEPROM byte-access controller.
`timescale 1ns/1ps
`default_nettype none
module ebac_ctrl_chk (
	input wire logic       ref_clk,       // CPU clock
	input wire logic       rst_b,         // Sync reset, low
	input wire logic [5:0] io_addr,       // I/O offset
	input wire logic       io_wr_en,      // Write strobe
	input wire logic       io_rd_en,      // Read strobe
	input wire logic [7:0] io_wdata,      // Write data
	input wire logic       global_irq_en, // Global enable
	input wire logic [7:0] io_rdata,      // Read data
	input wire logic       cpu_stall,     // Core halt
	input wire logic       ready_irq      // Ready level
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ----
	// Decoded accesses
	// ----
	logic ctl_wr;
	logic ctl_rd;
	logic high_rd;
	assign ctl_wr  = io_wr_en && (io_addr == ebac_pkg::NVM_CONTROL_OFF);
	assign ctl_rd  = io_rd_en && (io_addr == ebac_pkg::NVM_CONTROL_OFF);
	assign high_rd = io_rd_en && (io_addr == ebac_pkg::NVM_PTR_HIGH_OFF);
	// Stall shapes: a fetch halts four cycles, a program strobe two
	sequence s_fetch_stall;
		cpu_stall [*4] ##1 !cpu_stall;
	endsequence
	sequence s_prog_stall;
		cpu_stall [*2] ##1 !cpu_stall;
	endsequence
	chk_ctl_rsvd_zero: assert property (ctl_rd |=> io_rdata[7:6] == 2'h0)
		else $error("control reserved bits set");
	chk_high_rsvd_zero: assert property (high_rd |=> io_rdata[7:4] == 4'h0)
		else $error("pointer high reserved bits set");
	chk_fetch_stall: assert property (
		$rose(cpu_stall) && $past(io_wdata[0]) |-> s_fetch_stall)
		else $error("fetch stall length wrong");
	chk_prog_stall: assert property (
		$rose(cpu_stall) && !$past(io_wdata[0]) |-> s_prog_stall)
		else $error("program stall length wrong");
	chk_stall_cause: assert property (
		$rose(cpu_stall) |-> $past(ctl_wr))
		else $error("stall without control write");
	chk_irq_gated: assert property (
		ready_irq |-> $past(global_irq_en))
		else $error("ready irq without global enable");
	chk_irq_busy_low: assert property (
		$rose(cpu_stall) && !$past(io_wdata[0])
		&& $past(io_wdata[5:4]) != 2'h3 |=> !ready_irq [*3])
		else $error("ready irq while programming");
	chk_rdata_hold: assert property (
		!io_rd_en |=> $stable(io_rdata))
		else $error("read data moved without read");
	// Reset must quiet every output on the following edge
	chk_reset_quiet: assert property (
		disable iff (1'b0)
		!rst_b |=> !cpu_stall && !ready_irq && io_rdata == 8'h00)
		else $error("outputs not cleared by reset");
endmodule
bind ebac_ctrl ebac_ctrl_chk u_chk (.ref_clk, .rst_b, .io_addr, .io_wr_en,
	.io_rd_en, .io_wdata, .global_irq_en, .io_rdata, .cpu_stall, .ready_irq);
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the data EEPROM byte-access controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// Short timing keeps busy spans to a few cycles; a split span must
	// still outlast the refused writes and the status read made while busy
	localparam int         DIV = 2;
	localparam int         AT  = 9;
	localparam int         SP  = 5;
	localparam logic [5:0] CTL = ebac_pkg::NVM_CONTROL_OFF;
	localparam logic [5:0] BUF = ebac_pkg::NVM_BUFFER_OFF;
	localparam logic [5:0] PLO = ebac_pkg::NVM_PTR_LOW_OFF;
	localparam logic [5:0] PHI = ebac_pkg::NVM_PTR_HIGH_OFF;
	logic       ref_clk       = 1'b0;
	logic       rst_b         = 1'b0;
	logic [5:0] io_addr       = 6'h00;
	logic       io_wr_en      = 1'b0;
	logic       io_rd_en      = 1'b0;
	logic [7:0] io_wdata      = 8'h00;
	logic       global_irq_en = 1'b1;
	logic [7:0] io_rdata;
	logic       cpu_stall;
	logic       ready_irq;
	logic [7:0] rv;
	int         bad_count = 0;
	int         checks    = 0;
	int         low_cnt   = 0;

	ebac_ctrl #(.TICK_DIV_P(DIV), .ATOMIC_TICKS_P(AT), .SPLIT_TICKS_P(SP)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .io_addr(io_addr),
		.io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata),
		.global_irq_en(global_irq_en), .io_rdata(io_rdata),
		.cpu_stall(cpu_stall), .ready_irq(ready_irq));

	always #50 ref_clk = ~ref_clk;
	// Ready low time equals busy time, so it measures programming length
	always @(posedge ref_clk) begin
		if (!ready_irq) begin
			low_cnt <= low_cnt + 1;
		end
	end

	// ----
	// Access tasks; one idle cycle between transfers
	// ----
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		io_addr = a;
		io_wdata = d;
		io_wr_en = 1'b1;
		@(negedge ref_clk);
		io_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(negedge ref_clk);
		io_addr = a;
		io_rd_en = 1'b1;
		@(negedge ref_clk);
		io_rd_en = 1'b0;
		rv = io_rdata;
	endtask
	task automatic stall_chk(input int n);
		for (int i = 0; i < n; i++) begin
			chk(cpu_stall, 1'b1);
			@(negedge ref_clk);
		end
		chk(cpu_stall, 1'b0);
	endtask
	task automatic poll;
		int k;
		k = 0;
		rv = 8'h02;
		while (rv[1] && k < 200) begin
			rd(CTL);
			k++;
		end
	endtask
	task automatic fetch(input logic [7:0] exp);
		wr(CTL, 8'h09);
		stall_chk(4);
		rd(BUF);
		chk(rv, exp);
	endtask
	// Arm, wait gap, strobe; refused writes while busy; time and result
	task automatic prog(input logic [1:0] m, input logic [7:0] d,
			input int gap, input int n, input logic [7:0] exp);
		int base;
		wr(BUF, d);
		wr(CTL, {2'h0, m, 4'h8});
		wr(CTL, {2'h0, m, 4'hC});
		base = low_cnt;
		repeat (gap) @(negedge ref_clk);
		wr(CTL, {2'h0, m, 4'hA});
		stall_chk(2);
		if (n > 0) begin
			wr(CTL, {2'h0, ~m, 4'h9});
			chk(cpu_stall, 1'b0);
			wr(PLO, 8'h00);
			rd(CTL);
			chk(rv, {2'h0, m, 4'hA});
		end
		poll();
		chk(8'(low_cnt - base), 8'(n * DIV));
		fetch(exp);
	endtask
	task automatic final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(CTL);
		chk(rv, 8'h00);
		wr(PHI, 8'hFF);
		wr(PLO, 8'hFF);
		rd(PHI);
		chk(rv, 8'h0F);
		wr(CTL, 8'hC8);
		rd(CTL);
		chk(rv, 8'h08);
		rd(6'h3F);
		chk(rv, 8'h00);
		wr(CTL, 8'h0A);
		chk(cpu_stall, 1'b0);
		wr(CTL, 8'h0C);
		repeat (3) @(negedge ref_clk);
		wr(CTL, 8'h0A);
		chk(cpu_stall, 1'b0);
		rd(CTL);
		chk(rv, 8'h08);
		prog(2'h0, 8'h3C, 2, AT, 8'h3C);
		prog(2'h1, 8'h00, 0, SP, 8'hFF);
		prog(2'h2, 8'hA5, 1, SP, 8'hA5);
		prog(2'h2, 8'h0F, 0, SP, 8'h05);
		prog(2'h3, 8'h00, 0, 0, 8'h05);
		chk(ready_irq, 1'b1);
		global_irq_en = 1'b0;
		@(negedge ref_clk);
		chk(ready_irq, 1'b0);
		// Reset while a write-only runs: mode and the write survive
		wr(BUF, 8'h01);
		wr(CTL, 8'h2C);
		wr(CTL, 8'h2A);
		rst_b = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(CTL);
		chk(rv, 8'h22);
		poll();
		chk(rv, 8'h20);
		wr(PHI, 8'h0F);
		wr(PLO, 8'hFF);
		fetch(8'h01);
		final_report();
	end
	// Whole run is well under a thousand cycles
	initial begin
		repeat (3000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
